// ==== mem_map_pkg.sv ====
// Purpose: Shared constants and types for the core memory address map.
// Assumes: One 100 MHz core clock and a synchronous active-low reset.
// Notes: Every address, field position and reset value is named here once.
package mem_map_pkg;

	// Program memory.
	localparam logic [15:0] CODE_RESET_ADDR = 16'h0000;
	localparam logic [15:0] CODE_LAST_ADDR = 16'hFFFF;
	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam int VECTOR_STEP_LOG2 = 3;

	// External data space.
	localparam logic [15:0] SHARED_FIRST = 16'h0000;
	localparam logic [15:0] SHARED_LAST = 16'h13FF;
	localparam logic [15:0] IOCFG_FIRST = 16'h2000;
	localparam logic [15:0] IOCFG_LAST = 16'h27FF;
	localparam logic [15:0] BATT_FIRST = 16'h2800;
	localparam logic [15:0] BATT_LAST = 16'h287F;
	localparam logic [15:0] MUX_CYCLE_DIVIDER_ADDR = 16'h2100;
	localparam int MUX_CYCLE_DIVIDER_MSB = 7;
	localparam int MUX_CYCLE_DIVIDER_LSB = 4;
	localparam logic [3:0] MUX_CYCLE_DIVIDER_RESET = 4'h0;
	localparam logic [15:0] SAMPLE_AREA_BASE = 16'h0000;

	// Internal data memory.
	localparam logic [7:0] SFR_BASE = 8'h80;
	localparam logic [7:0] BIT_RAM_BASE = 8'h20;
	localparam logic [7:0] BANK_BASE = 8'h00;
	localparam int PSW_BANK_LSB = 3;
	localparam int PSW_BANK_MSB = 4;
	localparam int DPS_SEL_BIT = 0;

	// Special function register addresses.
	localparam logic [7:0] SFR_PRIMARY_LOW = 8'h82;
	localparam logic [7:0] SFR_PRIMARY_HIGH = 8'h83;
	localparam logic [7:0] SFR_SECONDARY_LOW = 8'h84;
	localparam logic [7:0] SFR_SECONDARY_HIGH = 8'h85;
	localparam logic [7:0] SFR_POINTER_SELECT = 8'h92;
	localparam logic [7:0] SFR_PAGE_HIGH = 8'hBF;
	localparam logic [7:0] SFR_STATUS_WORD = 8'hD0;

	// Reset values.
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// Value returned for any read that reaches nothing.
	localparam logic [7:0] UNDEFINED_READ = 8'hFF;

	typedef enum logic [1:0]
	{
		REGION_NONE = 2'b00,
		REGION_SHARED = 2'b01,
		REGION_IOCFG = 2'b10,
		REGION_BATT = 2'b11
	} region_type;

	typedef enum logic [1:0]
	{
		XS_IDLE = 2'b00,
		XS_ISSUE = 2'b01,
		XS_WAIT = 2'b10
	} xfer_state_type;

endpackage

// ==== ext_space_decode.sv ====
// Purpose: Decode a 16-bit external data address into its memory region.
// Assumes: Pure combinational logic on the core clock domain.
// Notes: Addresses in the holes between regions decode as no region.
`timescale 1ns/1ps
module ext_space_decode
(
	input wire logic [15:0] i_addr,
	output mem_map_pkg::region_type o_region
);

	always_comb
	begin
		if (i_addr <= mem_map_pkg::SHARED_LAST)
		begin
			o_region = mem_map_pkg::REGION_SHARED;
		end
		else if (i_addr >= mem_map_pkg::IOCFG_FIRST && i_addr <= mem_map_pkg::IOCFG_LAST)
		begin
			o_region = mem_map_pkg::REGION_IOCFG;
		end
		else if (i_addr >= mem_map_pkg::BATT_FIRST && i_addr <= mem_map_pkg::BATT_LAST)
		begin
			o_region = mem_map_pkg::REGION_BATT;
		end
		else
		begin
			o_region = mem_map_pkg::REGION_NONE;
		end
	end

endmodule

// ==== mcu_memory_address_map.sv ====
// Purpose: Memory address map and data pointer logic of the 8-bit core.
// Assumes: The execution unit holds each request for one cycle only.
// Notes: All outputs are registered; answers arrive one or more cycles late.
// Operation
// - 64 KB code space for fetches and code moves; only the fetch port is built here.
// - Fetching starts at address zero after reset.
// - Vectors eight bytes apart, first at three.
// - External 0x0000-0x13FF maps to shared RAM.
// - Nonzero divider lets samples fill low 0x40 bytes.
// - Decode configuration and battery-backed RAM ranges.
// - Only external moves access external data.
// - Register-indirect moves use page byte as high.
// - Pointer moves use selected 16-bit pointer.
// - Select bit zero picks primary, one secondary.
// - Switching pointers keeps both; ops use selected.
// - Internal data memory is 256 single-byte addresses.
// - Upper half: direct reaches registers, indirect RAM.
// - Four banks of eight registers, status-selected.
// - Bytes 0x20-0x2F bit addressable, rest byte.
// - Lower 128 bytes reachable direct and indirect.
// - Unimplemented registers read undefined, ignore writes.
// - Registers at multiples of eight bit addressable.
`timescale 1ns/1ps
module mcu_memory_address_map
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_code_req,
	input wire logic [15:0] i_code_addr,
	output logic o_flash_rd,
	output logic [15:0] o_flash_addr,
	input wire logic i_vector_req,
	input wire logic [2:0] i_vector_num,
	output logic o_vector_valid,
	output logic [15:0] o_vector_addr,
	input wire logic i_int_req,
	input wire logic i_int_we,
	input wire logic i_int_indirect,
	input wire logic i_int_bit,
	input wire logic [7:0] i_int_addr,
	input wire logic [7:0] i_int_wdata,
	output logic o_int_ack,
	output logic [7:0] o_int_rdata,
	input wire logic i_ptr_load,
	input wire logic [15:0] i_ptr_value,
	input wire logic i_ptr_inc,
	output logic [15:0] o_active_pointer,
	input wire logic i_xmove_req,
	input wire logic i_xmove_write,
	input wire logic i_xmove_use_pointer,
	input wire logic i_xmove_ri_sel,
	input wire logic [7:0] i_xmove_wdata,
	output logic o_xmove_busy,
	output logic o_xmove_ack,
	output logic [7:0] o_xmove_rdata,
	output logic [15:0] o_ext_addr,
	output logic [7:0] o_ext_wdata,
	output logic o_ext_we,
	output logic o_shared_en,
	output logic o_iocfg_en,
	output logic o_batt_en,
	input wire logic [7:0] i_shared_rdata,
	input wire logic [7:0] i_iocfg_rdata,
	input wire logic [7:0] i_batt_rdata,
	input wire logic i_sample_valid,
	input wire logic [5:0] i_sample_addr,
	input wire logic [7:0] i_sample_data,
	output logic o_sample_we,
	output logic [15:0] o_sample_addr,
	output logic [7:0] o_sample_data
);

	// Indirect reads of the upper half and all reads of the lower half share one array.
	logic [7:0] iram [0:255];
	logic [7:0] primary_pointer_low_reg;
	logic [7:0] primary_pointer_high_reg;
	logic [7:0] secondary_pointer_low_reg;
	logic [7:0] secondary_pointer_high_reg;
	logic [7:0] pointer_select_reg;
	logic [7:0] external_page_high_byte_reg;
	logic [7:0] program_status_word_reg;
	logic [3:0] mux_cycle_divider_reg;
	logic boot_pending_reg;
	mem_map_pkg::xfer_state_type xfer_state_reg;
	mem_map_pkg::region_type xfer_region_reg;
	logic xfer_write_reg;

	logic [7:0] target_addr;
	logic target_is_sfr;
	logic [7:0] sfr_value;
	logic [7:0] current_byte;
	logic [7:0] new_byte;
	logic sfr_write;
	logic ram_write;
	logic [15:0] selected_pointer;
	logic [7:0] ri_addr;
	logic [15:0] xmove_addr;
	mem_map_pkg::region_type xmove_region;
	logic xmove_accept;

	// A bit address below 0x80 lands in the 16-byte bit area, above it in an aligned register.
	function automatic logic [7:0] bit_byte_addr(input logic [7:0] addr);
		logic [7:0] result;
		if (addr < mem_map_pkg::SFR_BASE)
		begin
			result = mem_map_pkg::BIT_RAM_BASE + {4'h0, addr[6:3]};
		end
		else
		begin
			result = {addr[7:3], 3'b000};
		end
		return result;
	endfunction

	// Only direct accesses of the upper half go to the registers.
	function automatic logic is_sfr_access(input logic [7:0] addr, input logic indirect);
		return (addr >= mem_map_pkg::SFR_BASE) && !indirect;
	endfunction

	always_comb
	begin
		target_addr = i_int_bit ? bit_byte_addr(i_int_addr) : i_int_addr;
		// Bit operations are always direct, so the upper half is the register space.
		target_is_sfr = is_sfr_access(target_addr, i_int_indirect && !i_int_bit);
		case (target_addr)
			mem_map_pkg::SFR_PRIMARY_LOW: sfr_value = primary_pointer_low_reg;
			mem_map_pkg::SFR_PRIMARY_HIGH: sfr_value = primary_pointer_high_reg;
			mem_map_pkg::SFR_SECONDARY_LOW: sfr_value = secondary_pointer_low_reg;
			mem_map_pkg::SFR_SECONDARY_HIGH: sfr_value = secondary_pointer_high_reg;
			mem_map_pkg::SFR_POINTER_SELECT: sfr_value = pointer_select_reg;
			mem_map_pkg::SFR_PAGE_HIGH: sfr_value = external_page_high_byte_reg;
			mem_map_pkg::SFR_STATUS_WORD: sfr_value = program_status_word_reg;
			default: sfr_value = mem_map_pkg::UNDEFINED_READ;
		endcase
		current_byte = target_is_sfr ? sfr_value : iram[target_addr];
		new_byte = i_int_wdata;
		if (i_int_bit)
		begin
			new_byte = current_byte;
			new_byte[i_int_addr[2:0]] = i_int_wdata[0];
		end
		sfr_write = i_int_req && i_int_we && target_is_sfr;
		ram_write = i_int_req && i_int_we && !target_is_sfr;
	end

	always_comb
	begin
		if (pointer_select_reg[mem_map_pkg::DPS_SEL_BIT])
		begin
			selected_pointer = {secondary_pointer_high_reg, secondary_pointer_low_reg};
		end
		else
		begin
			selected_pointer = {primary_pointer_high_reg, primary_pointer_low_reg};
		end
		ri_addr = mem_map_pkg::BANK_BASE
			+ {3'b000, program_status_word_reg[mem_map_pkg::PSW_BANK_MSB:mem_map_pkg::PSW_BANK_LSB],
			3'b000} + {7'h00, i_xmove_ri_sel};
		if (i_xmove_use_pointer)
		begin
			xmove_addr = selected_pointer;
		end
		else
		begin
			xmove_addr = {external_page_high_byte_reg, iram[ri_addr]};
		end
		xmove_accept = i_xmove_req && (xfer_state_reg == mem_map_pkg::XS_IDLE);
	end

	ext_space_decode u_decode
	(
		.i_addr(xmove_addr),
		.o_region(xmove_region)
	);

	// Program memory fetch port; the first fetch after reset is forced to address zero.
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			boot_pending_reg <= 1'b1;
			o_flash_rd <= 1'b0;
			o_flash_addr <= mem_map_pkg::CODE_RESET_ADDR;
		end
		else if (boot_pending_reg)
		begin
			boot_pending_reg <= 1'b0;
			o_flash_rd <= 1'b1;
			o_flash_addr <= mem_map_pkg::CODE_RESET_ADDR;
		end
		else
		begin
			o_flash_rd <= i_code_req;
			if (i_code_req)
			begin
				o_flash_addr <= i_code_addr & mem_map_pkg::CODE_LAST_ADDR;
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_vector_valid <= 1'b0;
			o_vector_addr <= mem_map_pkg::VECTOR_BASE;
		end
		else
		begin
			o_vector_valid <= i_vector_req;
			if (i_vector_req)
			begin
				o_vector_addr <= mem_map_pkg::VECTOR_BASE
					+ (16'({i_vector_num}) << mem_map_pkg::VECTOR_STEP_LOG2);
			end
		end
	end

	// Internal RAM has no reset; software must not rely on its power-up contents.
	always_ff @(posedge i_clock)
	begin
		if (ram_write)
		begin
			iram[target_addr] <= new_byte;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_int_ack <= 1'b0;
			o_int_rdata <= 8'h00;
		end
		else
		begin
			o_int_ack <= i_int_req;
			if (i_int_req && !i_int_we)
			begin
				if (i_int_bit)
				begin
					o_int_rdata <= {7'h00, current_byte[i_int_addr[2:0]]};
				end
				else
				begin
					o_int_rdata <= current_byte;
				end
			end
		end
	end

	// Pointer instructions from the core take priority over a register write in the same cycle.
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			primary_pointer_low_reg <= mem_map_pkg::POINTER_RESET;
			primary_pointer_high_reg <= mem_map_pkg::POINTER_RESET;
			secondary_pointer_low_reg <= mem_map_pkg::POINTER_RESET;
			secondary_pointer_high_reg <= mem_map_pkg::POINTER_RESET;
		end
		else if (i_ptr_load || i_ptr_inc)
		begin
			if (pointer_select_reg[mem_map_pkg::DPS_SEL_BIT])
			begin
				{secondary_pointer_high_reg, secondary_pointer_low_reg} <=
					i_ptr_load ? i_ptr_value : selected_pointer + 16'h0001;
			end
			else
			begin
				{primary_pointer_high_reg, primary_pointer_low_reg} <=
					i_ptr_load ? i_ptr_value : selected_pointer + 16'h0001;
			end
		end
		else if (sfr_write)
		begin
			case (target_addr)
				mem_map_pkg::SFR_PRIMARY_LOW: primary_pointer_low_reg <= new_byte;
				mem_map_pkg::SFR_PRIMARY_HIGH: primary_pointer_high_reg <= new_byte;
				mem_map_pkg::SFR_SECONDARY_LOW: secondary_pointer_low_reg <= new_byte;
				mem_map_pkg::SFR_SECONDARY_HIGH: secondary_pointer_high_reg <= new_byte;
				default: primary_pointer_low_reg <= primary_pointer_low_reg;
			endcase
		end
	end

	// Only the select bit is stored, so toggling it never touches pointer contents.
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			pointer_select_reg <= mem_map_pkg::SELECT_RESET;
		end
		else if (sfr_write && target_addr == mem_map_pkg::SFR_POINTER_SELECT)
		begin
			pointer_select_reg <= {7'h00, new_byte[mem_map_pkg::DPS_SEL_BIT]};
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			external_page_high_byte_reg <= mem_map_pkg::PAGE_RESET;
		end
		else if (sfr_write && target_addr == mem_map_pkg::SFR_PAGE_HIGH)
		begin
			external_page_high_byte_reg <= new_byte;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			program_status_word_reg <= mem_map_pkg::STATUS_RESET;
		end
		else if (sfr_write && target_addr == mem_map_pkg::SFR_STATUS_WORD)
		begin
			program_status_word_reg <= new_byte;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_active_pointer <= {mem_map_pkg::POINTER_RESET, mem_map_pkg::POINTER_RESET};
		end
		else
		begin
			o_active_pointer <= selected_pointer;
		end
	end

	// The divider is snooped from external writes to the configuration RAM.
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			mux_cycle_divider_reg <= mem_map_pkg::MUX_CYCLE_DIVIDER_RESET;
		end
		else if (xmove_accept && i_xmove_write && xmove_addr == mem_map_pkg::MUX_CYCLE_DIVIDER_ADDR)
		begin
			mux_cycle_divider_reg <= i_xmove_wdata[mem_map_pkg::MUX_CYCLE_DIVIDER_MSB:mem_map_pkg::MUX_CYCLE_DIVIDER_LSB];
		end
	end

	// Samples use their own RAM port, so they never stall the core; none is written while the divider is zero.
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_sample_we <= 1'b0;
			o_sample_addr <= mem_map_pkg::SAMPLE_AREA_BASE;
			o_sample_data <= 8'h00;
		end
		else
		begin
			o_sample_we <= i_sample_valid && (mux_cycle_divider_reg != 4'h0);
			if (i_sample_valid)
			begin
				o_sample_addr <= mem_map_pkg::SAMPLE_AREA_BASE + {10'h000, i_sample_addr};
				o_sample_data <= i_sample_data;
			end
		end
	end

	// External move sequencer: issue one strobe, then wait one cycle for read data.
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			xfer_state_reg <= mem_map_pkg::XS_IDLE;
			xfer_region_reg <= mem_map_pkg::REGION_NONE;
			xfer_write_reg <= 1'b0;
			o_xmove_busy <= 1'b0;
			o_xmove_ack <= 1'b0;
			o_xmove_rdata <= 8'h00;
		end
		else
		begin
			o_xmove_ack <= 1'b0;
			case (xfer_state_reg)
				mem_map_pkg::XS_IDLE:
				begin
					if (xmove_accept)
					begin
						xfer_state_reg <= mem_map_pkg::XS_ISSUE;
						xfer_region_reg <= xmove_region;
						xfer_write_reg <= i_xmove_write;
						o_xmove_busy <= 1'b1;
					end
				end
				mem_map_pkg::XS_ISSUE:
				begin
					if (xfer_write_reg)
					begin
						xfer_state_reg <= mem_map_pkg::XS_IDLE;
						o_xmove_busy <= 1'b0;
						o_xmove_ack <= 1'b1;
					end
					else
					begin
						xfer_state_reg <= mem_map_pkg::XS_WAIT;
					end
				end
				mem_map_pkg::XS_WAIT:
				begin
					xfer_state_reg <= mem_map_pkg::XS_IDLE;
					o_xmove_busy <= 1'b0;
					o_xmove_ack <= 1'b1;
					case (xfer_region_reg)
						mem_map_pkg::REGION_SHARED: o_xmove_rdata <= i_shared_rdata;
						mem_map_pkg::REGION_IOCFG: o_xmove_rdata <= i_iocfg_rdata;
						mem_map_pkg::REGION_BATT: o_xmove_rdata <= i_batt_rdata;
						default: o_xmove_rdata <= mem_map_pkg::UNDEFINED_READ;
					endcase
				end
				default:
				begin
					xfer_state_reg <= mem_map_pkg::XS_IDLE;
					o_xmove_busy <= 1'b0;
				end
			endcase
		end
	end

	// Region strobes last exactly one cycle; an unmapped address raises none of them.
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_ext_addr <= 16'h0000;
			o_ext_wdata <= 8'h00;
			o_ext_we <= 1'b0;
			o_shared_en <= 1'b0;
			o_iocfg_en <= 1'b0;
			o_batt_en <= 1'b0;
		end
		else
		begin
			o_shared_en <= xmove_accept && xmove_region == mem_map_pkg::REGION_SHARED;
			o_iocfg_en <= xmove_accept && xmove_region == mem_map_pkg::REGION_IOCFG;
			o_batt_en <= xmove_accept && xmove_region == mem_map_pkg::REGION_BATT;
			o_ext_we <= xmove_accept && i_xmove_write && xmove_region != mem_map_pkg::REGION_NONE;
			if (xmove_accept)
			begin
				o_ext_addr <= xmove_addr;
				o_ext_wdata <= i_xmove_wdata;
			end
		end
	end

endmodule

// ==== mem_map_checker.sv ====
// Purpose: Port-level timing checks for the memory address map.
// Assumes: One core clock and a synchronous active-low reset.
// Notes: Watches only the top-level ports that these relations need.
`timescale 1ns/1ps
module mem_map_checker
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_code_req,
	input wire logic [15:0] i_code_addr,
	input wire logic o_flash_rd,
	input wire logic [15:0] o_flash_addr,
	input wire logic i_vector_req,
	input wire logic [2:0] i_vector_num,
	input wire logic o_vector_valid,
	input wire logic [15:0] o_vector_addr,
	input wire logic i_int_req,
	input wire logic o_int_ack,
	input wire logic i_xmove_req,
	input wire logic i_xmove_write,
	input wire logic o_xmove_busy,
	input wire logic o_xmove_ack,
	input wire logic [15:0] o_ext_addr,
	input wire logic o_ext_we,
	input wire logic o_shared_en,
	input wire logic o_iocfg_en,
	input wire logic o_batt_en,
	input wire logic i_sample_valid,
	input wire logic [5:0] i_sample_addr,
	input wire logic o_sample_we,
	input wire logic [15:0] o_sample_addr
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	property p_boot;
		$rose(i_rst_n) |=> o_flash_rd && o_flash_addr == 16'h0000;
	endproperty
	a_boot: assert property (p_boot)
		else $error("boot fetch missing");
	property p_code;
		i_code_req && $past(i_rst_n) |=> o_flash_rd && o_flash_addr == $past(i_code_addr);
	endproperty
	a_code: assert property (p_code)
		else $error("code read wrong");
	property p_vector;
		i_vector_req |=> o_vector_valid
			&& o_vector_addr == 16'h0003 + {10'h000, $past(i_vector_num), 3'b000};
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector address wrong");
	property p_int;
		i_int_req |=> o_int_ack;
	endproperty
	a_int: assert property (p_int)
		else $error("internal access not acknowledged");
	property p_xread;
		i_xmove_req && !i_xmove_write && !o_xmove_busy && !o_xmove_ack
			|=> (o_xmove_busy && !o_xmove_ack && !o_ext_we) [*2]
			##1 (o_xmove_ack && !o_xmove_busy);
	endproperty
	a_xread: assert property (p_xread)
		else $error("external read latency wrong");
	property p_xwrite;
		i_xmove_req && i_xmove_write && !o_xmove_busy && !o_xmove_ack
			|=> (o_xmove_busy && !o_xmove_ack
			&& o_ext_we == (o_shared_en || o_iocfg_en || o_batt_en))
			##1 (o_xmove_ack && !o_xmove_busy);
	endproperty
	a_xwrite: assert property (p_xwrite)
		else $error("external write sequence wrong");
	property p_hole;
		(o_ext_addr > 16'h13FF && o_ext_addr < 16'h2000) || o_ext_addr > 16'h287F
			|-> !o_shared_en && !o_iocfg_en && !o_batt_en && !o_ext_we;
	endproperty
	a_hole: assert property (p_hole)
		else $error("unmapped address enabled a memory");
	property p_region;
		(o_shared_en |-> o_ext_addr <= 16'h13FF)
			and (o_iocfg_en |-> o_ext_addr >= 16'h2000 && o_ext_addr <= 16'h27FF)
			and (o_batt_en |-> o_ext_addr >= 16'h2800 && o_ext_addr <= 16'h287F);
	endproperty
	a_region: assert property (p_region)
		else $error("region enable outside its range");
	property p_sample;
		o_sample_we |-> $past(i_sample_valid)
			&& o_sample_addr == {10'h000, $past(i_sample_addr)};
	endproperty
	a_sample: assert property (p_sample)
		else $error("sample write wrong");
endmodule

// ==== ext_mem_model.sv ====
// Purpose: Behavioural external data memories behind the region enables.
// Assumes: Read data is wanted the cycle after the enable.
// Notes: While a region's enable is low its data lines toggle so stale values never match.
`timescale 1ns/1ps
module ext_mem_model
(
	input wire logic i_clock,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_we,
	input wire logic i_shared_en,
	input wire logic i_iocfg_en,
	input wire logic i_batt_en,
	output logic [7:0] o_shared_rdata = 8'h00,
	output logic [7:0] o_iocfg_rdata = 8'h00,
	output logic [7:0] o_batt_rdata = 8'h00
);
	logic [7:0] mem [0:65535];

	always @(posedge i_clock)
	begin
		if (i_we && (i_shared_en || i_iocfg_en || i_batt_en))
			mem[i_addr] <= i_wdata;
		o_shared_rdata <= i_shared_en ? mem[i_addr] : ~o_shared_rdata;
		o_iocfg_rdata <= i_iocfg_en ? mem[i_addr] : ~o_iocfg_rdata;
		o_batt_rdata <= i_batt_en ? mem[i_addr] : ~o_batt_rdata;
	end
endmodule

// ==== mcu_memory_address_map_bench.sv ====
// Purpose: Self-checking bench for the memory address map.
// Assumes: Inputs change by non-blocking assignment on the rising edge.
// Notes: Latencies are checked by the bound checker, values here.
`timescale 1ns/1ps
module mcu_memory_address_map_bench;
	typedef struct {logic [15:0] a; logic [7:0] d; mem_map_pkg::region_type r;} row_type;
	logic i_clock = 1'b0, i_rst_n = 1'b0, i_code_req = 1'b0, i_vector_req = 1'b0;
	logic i_int_req = 1'b0, i_int_we = 1'b0, i_int_indirect = 1'b0, i_int_bit = 1'b0;
	logic i_ptr_load = 1'b0, i_ptr_inc = 1'b0, i_xmove_req = 1'b0, i_xmove_write = 1'b0;
	logic i_xmove_use_pointer = 1'b0, i_xmove_ri_sel = 1'b0, i_sample_valid = 1'b0;
	logic [15:0] i_code_addr = 16'h0000, i_ptr_value = 16'h0000;
	logic [7:0] i_int_addr = 8'h00, i_int_wdata = 8'h00, i_xmove_wdata = 8'h00;
	logic [7:0] i_sample_data = 8'h00, i_shared_rdata, i_iocfg_rdata, i_batt_rdata, rd;
	logic [2:0] i_vector_num = 3'h0;
	logic [5:0] i_sample_addr = 6'h00;
	logic o_flash_rd, o_vector_valid, o_int_ack, o_xmove_busy, o_xmove_ack, o_ext_we;
	logic o_shared_en, o_iocfg_en, o_batt_en, o_sample_we;
	logic [15:0] o_flash_addr, o_vector_addr, o_active_pointer, o_ext_addr, o_sample_addr;
	logic [7:0] o_int_rdata, o_xmove_rdata, o_ext_wdata, o_sample_data;
	logic [1:0] seen_reg;
	int num_errors = 0, check_count = 0, cycles = 0;
	row_type rows [10] = '{
		'{16'h0000, 8'hA5, mem_map_pkg::REGION_SHARED}, '{16'h13FF, 8'h3C, mem_map_pkg::REGION_SHARED},
		'{16'h1400, 8'h77, mem_map_pkg::REGION_NONE}, '{16'h1FFF, 8'h12, mem_map_pkg::REGION_NONE},
		'{16'h2000, 8'h11, mem_map_pkg::REGION_IOCFG}, '{16'h27FF, 8'h22, mem_map_pkg::REGION_IOCFG},
		'{16'h2800, 8'h33, mem_map_pkg::REGION_BATT}, '{16'h287F, 8'h44, mem_map_pkg::REGION_BATT},
		'{16'h2880, 8'h55, mem_map_pkg::REGION_NONE}, '{16'hFFFF, 8'h66, mem_map_pkg::REGION_NONE}};

	mcu_memory_address_map uut (.*);
	ext_mem_model mem_model (.i_clock(i_clock), .i_addr(o_ext_addr), .i_wdata(o_ext_wdata),
		.i_we(o_ext_we), .i_shared_en(o_shared_en), .i_iocfg_en(o_iocfg_en),
		.i_batt_en(o_batt_en), .o_shared_rdata(i_shared_rdata),
		.o_iocfg_rdata(i_iocfg_rdata), .o_batt_rdata(i_batt_rdata));

	initial forever #5 i_clock = ~i_clock;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic int_acc(input logic we, ind, bt, input logic [7:0] a, d);
		@(posedge i_clock);
		i_int_req <= 1'b1;
		i_int_we <= we;
		i_int_indirect <= ind;
		i_int_bit <= bt;
		i_int_addr <= a;
		i_int_wdata <= d;
		@(posedge i_clock);
		i_int_req <= 1'b0;
		#1;
		rd = o_int_rdata;
	endtask

	// Waits a bounded number of cycles, since a lost ack must not hang the run.
	task automatic xmove(input logic we, up, ri, input logic [7:0] d);
		@(posedge i_clock);
		i_xmove_req <= 1'b1;
		i_xmove_write <= we;
		i_xmove_use_pointer <= up;
		i_xmove_ri_sel <= ri;
		i_xmove_wdata <= d;
		@(posedge i_clock);
		i_xmove_req <= 1'b0;
		seen_reg = 2'b00;
		for (int k = 0; k < 6; k++)
		begin
			#1;
			if (o_shared_en || o_iocfg_en || o_batt_en)
				seen_reg = {o_batt_en | o_iocfg_en, o_batt_en | o_shared_en};
			if (o_xmove_ack)
				break;
			@(posedge i_clock);
		end
		rd = o_xmove_rdata;
	endtask

	task automatic ptr_op(input logic ld, inc, input logic [15:0] v);
		@(posedge i_clock);
		i_ptr_load <= ld;
		i_ptr_inc <= inc;
		i_ptr_value <= v;
		@(posedge i_clock);
		i_ptr_load <= 1'b0;
		i_ptr_inc <= 1'b0;
		@(posedge i_clock);
		#1;
	endtask

	task automatic sample(input logic [5:0] a);
		@(posedge i_clock);
		i_sample_valid <= 1'b1;
		i_sample_addr <= a;
		i_sample_data <= 8'h9E;
		@(posedge i_clock);
		i_sample_valid <= 1'b0;
		#1;
	endtask

	task print_verdict;
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (15) @(posedge i_clock);
		#1 chk(o_vector_addr, 16'h0003);
		chk(o_active_pointer, 16'h0000);
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		#1 chk({o_flash_rd, o_flash_addr[14:0]}, 16'h8000);
		foreach (rows[n])
		begin
			ptr_op(1'b1, 1'b0, rows[n].a);
			xmove(1'b1, 1'b1, 1'b0, rows[n].d);
			chk({14'h0, seen_reg}, {14'h0, rows[n].r});
			xmove(1'b0, 1'b1, 1'b0, 8'h00);
			chk(o_ext_addr, rows[n].a);
			chk({8'h00, rd}, rows[n].r == mem_map_pkg::REGION_NONE ? 16'h00FF : {8'h00, rows[n].d});
		end
		for (int v = 0; v < 8; v++)
		begin
			@(posedge i_clock);
			i_vector_req <= 1'b1;
			i_vector_num <= v[2:0];
			@(posedge i_clock);
			i_vector_req <= 1'b0;
			#1 chk(o_vector_addr, 16'h0003 + 16'(v * 8));
		end
		@(posedge i_clock);
		i_code_req <= 1'b1;
		i_code_addr <= 16'hFFFF;
		@(posedge i_clock);
		i_code_req <= 1'b0;
		#1 chk(o_flash_addr, 16'hFFFF);
		int_acc(1'b1, 1'b0, 1'b0, mem_map_pkg::SFR_POINTER_SELECT, 8'h01);
		ptr_op(1'b1, 1'b0, 16'h00FF);
		ptr_op(1'b0, 1'b1, 16'h0000);
		chk(o_active_pointer, 16'h0100);
		int_acc(1'b0, 1'b0, 1'b0, mem_map_pkg::SFR_SECONDARY_HIGH, 8'h00);
		chk({8'h00, rd}, 16'h0001);
		int_acc(1'b1, 1'b0, 1'b0, mem_map_pkg::SFR_POINTER_SELECT, 8'h00);
		repeat (2) @(posedge i_clock);
		#1 chk(o_active_pointer, 16'hFFFF);
		int_acc(1'b1, 1'b0, 1'b0, mem_map_pkg::SFR_STATUS_WORD, 8'h18);
		int_acc(1'b1, 1'b0, 1'b0, 8'h19, 8'h7F);
		int_acc(1'b1, 1'b0, 1'b0, mem_map_pkg::SFR_PAGE_HIGH, 8'h28);
		xmove(1'b1, 1'b0, 1'b1, 8'h5C);
		chk(o_ext_addr, 16'h287F);
		xmove(1'b0, 1'b0, 1'b1, 8'h00);
		chk({8'h00, rd}, 16'h005C);
		int_acc(1'b1, 1'b1, 1'b0, 8'h90, 8'h33);
		int_acc(1'b0, 1'b1, 1'b0, 8'h90, 8'h00);
		chk({8'h00, rd}, 16'h0033);
		int_acc(1'b0, 1'b0, 1'b0, 8'h90, 8'h00);
		chk({8'h00, rd}, 16'h00FF);
		int_acc(1'b1, 1'b0, 1'b0, 8'h90, 8'hC3);
		int_acc(1'b0, 1'b1, 1'b0, 8'h90, 8'h00);
		chk({8'h00, rd}, 16'h0033);
		int_acc(1'b1, 1'b0, 1'b0, 8'h40, 8'h44);
		int_acc(1'b0, 1'b1, 1'b0, 8'h40, 8'h00);
		chk({8'h00, rd}, 16'h0044);
		int_acc(1'b1, 1'b0, 1'b0, 8'h21, 8'h00);
		int_acc(1'b1, 1'b0, 1'b1, 8'h0A, 8'h01);
		int_acc(1'b0, 1'b0, 1'b0, 8'h21, 8'h00);
		chk({8'h00, rd}, 16'h0004);
		int_acc(1'b1, 1'b0, 1'b1, 8'hD5, 8'h01);
		int_acc(1'b0, 1'b0, 1'b0, mem_map_pkg::SFR_STATUS_WORD, 8'h00);
		chk({8'h00, rd}, 16'h0038);
		sample(6'h3F);
		chk({15'h0, o_sample_we}, 16'h0000);
		ptr_op(1'b1, 1'b0, mem_map_pkg::MUX_CYCLE_DIVIDER_ADDR);
		xmove(1'b1, 1'b1, 1'b0, 8'h70);
		sample(6'h3F);
		chk({o_sample_we, o_sample_addr[14:0]}, 16'h803F);
		chk({8'h00, o_sample_data}, 16'h009E);
		print_verdict();
	end
endmodule

bind mcu_memory_address_map mem_map_checker chk_inst (.*);
